// File: rtl/afe_control_registers.sv
// Control register bank of the analog front end
//
// Functional notes
// RULE1: Host writes zeros into every unused upper bit of a data word.
// RULE2: Front-end bit 2 enables the optical-black clamp; resets to one.
// RULE3: Front-end bit 3 picks fast clamp settling; resets to zero.
// RULE4: Front-end bit 4 makes gain changes trigger a very fast re-clamp.
// RULE5: Front-end bit 5 blanks outputs to zero or to clamp level.
// RULE6: Front-end bit 6 bypasses input dc-restore during pixel blanking.
// RULE7: Front-end bits 14:11 pick one of sixteen substrate-count sources.
// RULE8: Output bit 0 tri-states the data outputs; resets to driven.
// RULE9: Output bit 1 makes the output latch transparent, else phase latched.
// RULE10: Ten-bit amplifier gain maps linearly, 6 to 42 dB, 0.035 dB steps.
// RULE11: Ten-bit clamp target, quarter-code steps, resets to 0x1ec.
// RULE12: Two-bit standby field, 0 normal, 1 to 3 standby; resets to 3.
// RULE13: Sampler gain codes 0 to 3 give -3, 0, +3, +6 dB; resets to 1.
// RULE14: Offsets 0x00 and 0x01 update when the last data bit arrives.
// RULE15: Offsets 0x04 to 0x06 wait pending until vertical sync falls.
// RULE16: Each write is a 12-bit address then 28-bit data, LSB first.
`timescale 1ns/1ns
`include "afe_defines.svh"
module afe_control_registers import afe_pkg::*; #(
   parameter int DOUT_W = `AFE_DOUT_W,
   parameter int SRC_N = 16
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_serial_clk,
   input wire logic i_serial_data,
   input wire logic i_serial_load_n,
   input wire logic i_vsync,
   input wire logic i_pixel_blanking,
   input wire logic [SRC_N-1:0] i_substrate_sources,
   input wire logic [DOUT_W-1:0] i_adc_data,
   input wire logic i_dout_phase,
   output logic [1:0] o_standby_mode,
   output logic o_black_clamp_on,
   output logic o_clamp_settle_fast,
   output logic o_quick_reclamp,
   output logic o_dc_restore_en,
   output logic o_substrate_count_out,
   output logic [DOUT_W-1:0] o_dout,
   output logic o_dout_oe,
   output logic [1:0] o_sampler_gain,
   output logic [3:0] o_sampler_gain_db,
   output logic [9:0] o_amplifier_gain_code,
   output logic [15:0] o_amplifier_gain_mdb,
   output logic [9:0] o_black_level_target
);

   afe_wr_if wr_bus ();

   logic [14:0] fe_reg, fe_next;
   logic [3:0] dc_reg, dc_next;
   afe_frame_t pend_reg, pend_next;
   afe_frame_t appl_reg, appl_next;
   logic reclamp_reg, reclamp_next;
   logic sub_reg, sub_next;
   logic restore_reg, restore_next;
   logic [15:0] mdb_reg, mdb_next;
   logic [3:0] sg_db_reg, sg_db_next;
   logic vd_meta_reg;
   logic vd_sync_reg;
   logic vd_prev_reg;
   logic vd_fall;
   logic [3:0] sub_sel;

   // Serial port front end
   afe_serial_rx u_rx (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_serial_clk(i_serial_clk),
      .i_serial_data(i_serial_data),
      .i_serial_load_n(i_serial_load_n),
      .wr(wr_bus.src)
   );

   // Vertical sync synchroniser and falling edge
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         vd_meta_reg <= 1'b1;
         vd_sync_reg <= 1'b1;
         vd_prev_reg <= 1'b1;
      end else begin
         vd_meta_reg <= i_vsync;
         vd_sync_reg <= vd_meta_reg;
         vd_prev_reg <= vd_sync_reg;
      end
   end

   assign vd_fall = vd_prev_reg & ~vd_sync_reg;
   assign sub_sel = fe_reg[`AFE_SUBSEL_MSB:`AFE_SUBSEL_LSB];

   // Sampler gain code to dB
   function automatic logic [3:0] afe_sg_db(input logic [1:0] code);
      logic [3:0] db;
      db = `AFE_SG_DB_1;
      case (code)
         2'h0: db = `AFE_SG_DB_0;
         2'h1: db = `AFE_SG_DB_1;
         2'h2: db = `AFE_SG_DB_2;
         2'h3: db = `AFE_SG_DB_3;
         default: db = `AFE_SG_DB_1;
      endcase
      return db;
   endfunction

   // Register writes, frame transfer and quick re-clamp request
   always_comb begin
      fe_next = fe_reg;
      dc_next = dc_reg;
      pend_next = pend_reg;
      appl_next = appl_reg;
      reclamp_next = 1'b0;
      if (wr_bus.valid) begin
         case (wr_bus.addr)
            `AFE_OFF_FRONTEND: begin
               fe_next = wr_bus.data[14:0] & `AFE_FE_MASK; // RULE14
            end
            `AFE_OFF_DOUT_CTRL: begin
               dc_next = wr_bus.data[3:0]; // RULE14
            end
            `AFE_OFF_SAMPLER_GAIN: begin
               pend_next.sampler = wr_bus.data[1:0]; // RULE15
            end
            `AFE_OFF_AMP_GAIN: begin
               pend_next.amp = wr_bus.data[9:0]; // RULE15
            end
            `AFE_OFF_CLAMP_TARGET: begin
               pend_next.clamp = wr_bus.data[9:0]; // RULE15
            end
            default: begin
            end
         endcase
      end
      // A write in the sync cycle stays pending for the next frame
      if (vd_fall) begin
         appl_next = pend_reg; // RULE15
         reclamp_next = fe_reg[`AFE_BIT_QUICK_RECLAMP] &&
            (pend_reg.amp != appl_reg.amp); // RULE4
      end
   end

   // Derived outputs: substrate mux, dc-restore, gain scaling
   always_comb begin
      sub_next = i_substrate_sources[sub_sel]; // RULE7
      restore_next = ~(i_pixel_blanking &&
         fe_reg[`AFE_BIT_RESTORE_BYP]); // RULE6
      mdb_next = `AFE_GAIN_BASE_MDB +
         16'(appl_next.amp) * `AFE_GAIN_STEP_MDB; // RULE10
      sg_db_next = afe_sg_db(appl_next.sampler); // RULE13
   end

   // Register bank state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fe_reg <= `AFE_FE_RESET;
         dc_reg <= `AFE_DC_RESET;
         pend_reg <= {`AFE_SG_RESET, `AFE_AMP_RESET, `AFE_CLAMP_RESET};
         appl_reg <= {`AFE_SG_RESET, `AFE_AMP_RESET, `AFE_CLAMP_RESET};
         reclamp_reg <= 1'b0;
         sub_reg <= 1'b0;
         restore_reg <= 1'b1;
         mdb_reg <= `AFE_MDB_RESET;
         sg_db_reg <= `AFE_SG_DB_1;
      end else begin
         fe_reg <= fe_next;
         dc_reg <= dc_next;
         pend_reg <= pend_next;
         appl_reg <= appl_next;
         reclamp_reg <= reclamp_next;
         sub_reg <= sub_next;
         restore_reg <= restore_next;
         mdb_reg <= mdb_next;
         sg_db_reg <= sg_db_next;
      end
   end

   // Output pins of the bank
   assign o_standby_mode = fe_reg[`AFE_STANDBY_MSB:`AFE_STANDBY_LSB]; // RULE12
   assign o_black_clamp_on = fe_reg[`AFE_BIT_CLAMP_ON]; // RULE2
   assign o_clamp_settle_fast = fe_reg[`AFE_BIT_SETTLE_FAST]; // RULE3
   assign o_quick_reclamp = reclamp_reg;
   assign o_dc_restore_en = restore_reg;
   assign o_substrate_count_out = sub_reg;
   assign o_sampler_gain = appl_reg.sampler;
   assign o_sampler_gain_db = sg_db_reg;
   assign o_amplifier_gain_code = appl_reg.amp;
   assign o_amplifier_gain_mdb = mdb_reg;
   assign o_black_level_target = appl_reg.clamp; // RULE11

   // Data output path
   afe_dout_stage #(
      .DOUT_W(DOUT_W)
   ) u_dout (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_adc_data(i_adc_data),
      .i_pixel_blanking(i_pixel_blanking),
      .i_blank_sel(fe_reg[`AFE_BIT_BLANK_SEL]),
      .i_blank_level(appl_reg.clamp),
      .i_latch_bypass(dc_reg[`AFE_BIT_LATCH_BYP]),
      .i_tristate(dc_reg[`AFE_BIT_TRISTATE]),
      .i_dout_phase(i_dout_phase),
      .o_dout(o_dout),
      .o_dout_oe(o_dout_oe)
   );

   // Checks on the register bank
   sequence s_fe_write;
      wr_bus.valid && wr_bus.addr == `AFE_OFF_FRONTEND;
   endsequence

   sequence s_amp_write;
      wr_bus.valid && wr_bus.addr == `AFE_OFF_AMP_GAIN;
   endsequence

   property p_clamp_on;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_fe_write |=> o_black_clamp_on == $past(wr_bus.data[2]);
   endproperty
   a_clamp_on: assert property (p_clamp_on) // RULE2
      else $error("clamp enable not taken from write");

   property p_settle_fast;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_fe_write |=> o_clamp_settle_fast == $past(wr_bus.data[3]);
   endproperty
   a_settle_fast: assert property (p_settle_fast) // RULE3
      else $error("settling select not taken from write");

   property p_standby;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_fe_write |=> o_standby_mode == $past(wr_bus.data[1:0]);
   endproperty
   a_standby: assert property (p_standby) // RULE14
      else $error("front-end register not updated at once");

   property p_reclamp_cause;
      @(posedge i_clk) disable iff (!i_reset_n)
      o_quick_reclamp |-> $past(vd_fall) &&
         $past(fe_reg[`AFE_BIT_QUICK_RECLAMP]) &&
         $changed(o_amplifier_gain_code);
   endproperty
   a_reclamp_cause: assert property (p_reclamp_cause) // RULE4
      else $error("re-clamp without a gain change");

   // Armed re-clamp must fire whenever the applied gain changes
   property p_reclamp_fire;
      @(posedge i_clk) disable iff (!i_reset_n)
      vd_fall && fe_reg[`AFE_BIT_QUICK_RECLAMP] &&
         pend_reg.amp != appl_reg.amp |=> o_quick_reclamp;
   endproperty
   a_reclamp_fire: assert property (p_reclamp_fire) // RULE4
      else $error("gain change gave no re-clamp");

   sequence s_dc_write;
      wr_bus.valid && wr_bus.addr == `AFE_OFF_DOUT_CTRL;
   endsequence

   // Output enable follows the inverted tri-state bit two cycles after the write strobe
   property p_dc_write;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_dc_write |=> ##1 o_dout_oe == !$past(wr_bus.data[0], 2);
   endproperty
   a_dc_write: assert property (p_dc_write) // RULE14
      else $error("output control not updated at once");

   property p_restore;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_pixel_blanking && fe_reg[`AFE_BIT_RESTORE_BYP] |=> !o_dc_restore_en;
   endproperty
   a_restore: assert property (p_restore) // RULE6
      else $error("dc-restore active while bypassed");

   property p_sub_mux;
      @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> o_substrate_count_out ==
         $past(i_substrate_sources[sub_sel]);
   endproperty
   a_sub_mux: assert property (p_sub_mux) // RULE7
      else $error("substrate source mismatch");

   property p_amp_pending;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_amp_write ##1 !vd_fall |=> $stable(o_amplifier_gain_code);
   endproperty
   a_amp_pending: assert property (p_amp_pending) // RULE15
      else $error("gain applied before vertical sync");

   property p_frame_apply;
      @(posedge i_clk) disable iff (!i_reset_n)
      vd_fall |=> o_black_level_target == $past(pend_reg.clamp) &&
         o_sampler_gain == $past(pend_reg.sampler);
   endproperty
   a_frame_apply: assert property (p_frame_apply) // RULE15
      else $error("pending values not applied at sync");

   property p_gain_scale;
      @(posedge i_clk) disable iff (!i_reset_n)
      $changed(o_amplifier_gain_code) |-> o_amplifier_gain_mdb ==
         `AFE_GAIN_BASE_MDB + 16'(o_amplifier_gain_code) * `AFE_GAIN_STEP_MDB;
   endproperty
   a_gain_scale: assert property (p_gain_scale) // RULE10
      else $error("gain scaling wrong");

   property p_sampler_db;
      @(posedge i_clk) disable iff (!i_reset_n)
      o_sampler_gain == 2'h3 |-> o_sampler_gain_db == `AFE_SG_DB_3;
   endproperty
   a_sampler_db: assert property (p_sampler_db) // RULE13
      else $error("sampler gain dB wrong");

endmodule

// File: common/afe_defines.svh
// Offsets, field positions, reset values and counts of the control bank
`ifndef AFE_DEFINES_SVH
`define AFE_DEFINES_SVH

// Serial word layout
`define AFE_ADDR_W 12
`define AFE_DATA_W 28
`define AFE_CNT_W 5
`define AFE_ADDR_LAST 5'd11
`define AFE_DATA_LAST 5'd27
`define AFE_ADDR_STEP 12'h001

// Register offsets
`define AFE_OFF_FRONTEND 12'h000
`define AFE_OFF_DOUT_CTRL 12'h001
`define AFE_OFF_SAMPLER_GAIN 12'h004
`define AFE_OFF_AMP_GAIN 12'h005
`define AFE_OFF_CLAMP_TARGET 12'h006

// Front-end control register
`define AFE_FE_W 15
`define AFE_FE_RESET 15'h0007
`define AFE_FE_MASK 15'h787f
`define AFE_STANDBY_MSB 1
`define AFE_STANDBY_LSB 0
`define AFE_BIT_CLAMP_ON 2
`define AFE_BIT_SETTLE_FAST 3
`define AFE_BIT_QUICK_RECLAMP 4
`define AFE_BIT_BLANK_SEL 5
`define AFE_BIT_RESTORE_BYP 6
`define AFE_SUBSEL_MSB 14
`define AFE_SUBSEL_LSB 11

// Data output control register
`define AFE_DC_W 4
`define AFE_DC_RESET 4'h8
`define AFE_BIT_TRISTATE 0
`define AFE_BIT_LATCH_BYP 1

// Frame-updated registers
`define AFE_SG_W 2
`define AFE_GAIN_W 10
`define AFE_SG_RESET 2'h1
`define AFE_AMP_RESET 10'h00f
`define AFE_CLAMP_RESET 10'h1ec

// Gain scaling in milli-dB
`define AFE_GAIN_BASE_MDB 16'h1770
`define AFE_GAIN_STEP_MDB 16'h0023
`define AFE_MDB_RESET 16'h197d

// Sampler gain in dB, two's complement
`define AFE_SG_DB_0 4'hd
`define AFE_SG_DB_1 4'h0
`define AFE_SG_DB_2 4'h3
`define AFE_SG_DB_3 4'h6

// Output word
`define AFE_DOUT_W 12

`endif

// File: common/afe_pkg.sv
// Types shared by the control bank modules
package afe_pkg;

   // Serial receiver states
   typedef enum logic [1:0] {
      AFE_RX_IDLE = 2'b00,
      AFE_RX_ADDR = 2'b01,
      AFE_RX_DATA = 2'b10
   } afe_rx_state_t;

   // Frame-updated gain and clamp values
   typedef struct packed {
      logic [1:0] sampler;
      logic [9:0] amp;
      logic [9:0] clamp;
   } afe_frame_t;

endpackage

// File: common/afe_wr_if.sv
// Completed register write from the serial receiver
`timescale 1ns/1ns
interface afe_wr_if;
   logic valid;
   logic [11:0] addr;
   logic [27:0] data;

   modport src (output valid, output addr, output data);
   modport dst (input valid, input addr, input data);
endinterface

// File: rtl/afe_serial_rx.sv
// Three-wire serial write receiver with address auto-increment
`timescale 1ns/1ns
`include "afe_defines.svh"
module afe_serial_rx import afe_pkg::*; (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_serial_clk,
   input wire logic i_serial_data,
   input wire logic i_serial_load_n,
   afe_wr_if.src wr
);

   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic sck_prev_reg;
   logic sck_rise;
   logic sdi;
   logic load_n;
   afe_rx_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [11:0] addr_reg, addr_next;
   logic [27:0] data_reg, data_next;
   logic valid_reg, valid_next;
   logic [11:0] out_addr_reg, out_addr_next;
   logic [27:0] out_data_reg, out_data_next;

   // Two-stage synchronisers for the pins, plus clock edge history
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_reg <= 3'h7;
         sync_reg <= 3'h7;
         sck_prev_reg <= 1'b1;
      end else begin
         meta_reg <= {i_serial_load_n, i_serial_data, i_serial_clk};
         sync_reg <= meta_reg;
         sck_prev_reg <= sync_reg[0];
      end
   end

   assign sck_rise = sync_reg[0] & ~sck_prev_reg;
   assign sdi = sync_reg[1];
   assign load_n = sync_reg[2];

   // Shift address then data words, LSB first; load high aborts
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      valid_next = 1'b0;
      out_addr_next = out_addr_reg;
      out_data_next = out_data_reg;
      case (state_reg)
         AFE_RX_IDLE: begin
            cnt_next = 5'h00;
            if (!load_n) begin
               state_next = AFE_RX_ADDR;
            end
         end
         AFE_RX_ADDR: begin
            if (load_n) begin
               state_next = AFE_RX_IDLE;
            end else if (sck_rise) begin
               addr_next = {sdi, addr_reg[11:1]}; // RULE16
               if (cnt_reg == `AFE_ADDR_LAST) begin
                  state_next = AFE_RX_DATA;
                  cnt_next = 5'h00;
               end else begin
                  cnt_next = cnt_reg + 5'h01;
               end
            end
         end
         AFE_RX_DATA: begin
            if (load_n) begin
               state_next = AFE_RX_IDLE;
            end else if (sck_rise) begin
               data_next = {sdi, data_reg[27:1]}; // RULE16
               if (cnt_reg == `AFE_DATA_LAST) begin
                  valid_next = 1'b1; // RULE14
                  out_addr_next = addr_reg;
                  out_data_next = {sdi, data_reg[27:1]};
                  addr_next = addr_reg + `AFE_ADDR_STEP;
                  cnt_next = 5'h00;
               end else begin
                  cnt_next = cnt_reg + 5'h01;
               end
            end
         end
         default: begin
            state_next = AFE_RX_IDLE;
         end
      endcase
   end

   // Receiver state registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= AFE_RX_IDLE;
         cnt_reg <= 5'h00;
         addr_reg <= 12'h000;
         data_reg <= 28'h0000000;
         valid_reg <= 1'b0;
         out_addr_reg <= 12'h000;
         out_data_reg <= 28'h0000000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         valid_reg <= valid_next;
         out_addr_reg <= out_addr_next;
         out_data_reg <= out_data_next;
      end
   end

   assign wr.valid = valid_reg;
   assign wr.addr = out_addr_reg;
   assign wr.data = out_data_reg;

   // Write strobe only after the last data bit of a word
   property p_word_complete;
      @(posedge i_clk) disable iff (!i_reset_n)
      valid_reg |-> $past(state_reg) == AFE_RX_DATA &&
         $past(cnt_reg) == `AFE_DATA_LAST && $past(sck_rise);
   endproperty
   a_word_complete: assert property (p_word_complete) // RULE16
      else $error("write strobe without a full data word");

endmodule

// File: rtl/afe_dout_stage.sv
// Data output path: blanking value, output latch and tri-state enable
`timescale 1ns/1ns
`include "afe_defines.svh"
module afe_dout_stage import afe_pkg::*; #(
   parameter int DOUT_W = `AFE_DOUT_W
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [DOUT_W-1:0] i_adc_data,
   input wire logic i_pixel_blanking,
   input wire logic i_blank_sel,
   input wire logic [9:0] i_blank_level,
   input wire logic i_latch_bypass,
   input wire logic i_tristate,
   input wire logic i_dout_phase,
   output logic [DOUT_W-1:0] o_dout,
   output logic o_dout_oe
);

   logic [DOUT_W-1:0] dout_reg, dout_next;
   logic oe_reg, oe_next;
   logic [DOUT_W-1:0] word;

   // Blanking replaces the sample with zero or the clamp level in codes
   always_comb begin
      word = i_adc_data;
      if (i_pixel_blanking) begin
         word = i_blank_sel ? DOUT_W'(i_blank_level[9:2]) : '0; // RULE5
      end
   end

   // Latch at the output phase, or follow every cycle when transparent
   always_comb begin
      dout_next = dout_reg;
      if (i_latch_bypass || i_dout_phase) begin
         dout_next = word; // RULE9
      end
      oe_next = ~i_tristate; // RULE8
   end

   // Output registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dout_reg <= '0;
         oe_reg <= 1'b0;
      end else begin
         dout_reg <= dout_next;
         oe_reg <= oe_next;
      end
   end

   assign o_dout = dout_reg;
   assign o_dout_oe = oe_reg;

   property p_blank_zero;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_pixel_blanking && !i_blank_sel && i_latch_bypass |=> o_dout == '0;
   endproperty
   a_blank_zero: assert property (p_blank_zero) // RULE5
      else $error("blanked output not zero");

   property p_tristate;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_tristate |=> !o_dout_oe;
   endproperty
   a_tristate: assert property (p_tristate) // RULE8
      else $error("outputs driven while tri-stated");

   property p_latch_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      !i_latch_bypass && !i_dout_phase |=> $stable(o_dout);
   endproperty
   a_latch_hold: assert property (p_latch_hold) // RULE9
      else $error("output latch changed off phase");

endmodule

// File: sim/tb_top.sv
// Self-checking bench for the front-end control register bank
`timescale 1ns/1ns
`include "afe_defines.svh"
module tb_top;
   import afe_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic sck = 1'b0;
   logic sdata = 1'b0;
   logic sload_n = 1'b1;
   logic vsync = 1'b1;
   logic blank = 1'b0;
   logic phase = 1'b0;
   logic [15:0] srcs = 16'h0000;
   logic [11:0] adc = 12'h000;
   logic [1:0] stby, sg_o;
   logic clamp_on, settle, reclamp, restore_en, sub_out, oe;
   logic [11:0] dout;
   logic [3:0] db;
   logic [9:0] amp_o, clamp_o;
   logic [15:0] mdb_o;
   int errors = 0;
   int cmp_count = 0;
   int pulses = 0;
   logic [31:0] seed = 32'h9d8d;

   // Clock at 20 MHz
   always #25 i_clk = ~i_clk;

   afe_control_registers afe_control_registers_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial_clk(sck),
      .i_serial_data(sdata), .i_serial_load_n(sload_n), .i_vsync(vsync),
      .i_pixel_blanking(blank), .i_substrate_sources(srcs),
      .i_adc_data(adc), .i_dout_phase(phase), .o_standby_mode(stby),
      .o_black_clamp_on(clamp_on), .o_clamp_settle_fast(settle),
      .o_quick_reclamp(reclamp), .o_dc_restore_en(restore_en),
      .o_substrate_count_out(sub_out), .o_dout(dout), .o_dout_oe(oe),
      .o_sampler_gain(sg_o), .o_sampler_gain_db(db),
      .o_amplifier_gain_code(amp_o), .o_amplifier_gain_mdb(mdb_o),
      .o_black_level_target(clamp_o));

   // Counts one-cycle re-clamp pulses
   always @(posedge i_clk) begin
      if (reclamp === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   // Watchdog against a hung run
   initial begin
      repeat (100000) @(posedge i_clk);
      errors++;
      give_verdict();
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Expected gain in milli-dB
   function automatic logic [15:0] mdb(input logic [9:0] c);
      return 16'h1770 + 16'h0023 * {6'h00, c};
   endfunction

   // Expected sampler gain in dB
   function automatic logic [3:0] sg_db(input logic [1:0] c);
      case (c)
         2'h0: return 4'hd;
         2'h1: return 4'h0;
         2'h2: return 4'h3;
         default: return 4'h6;
      endcase
   endfunction

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Wait n edges, then step just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // Serial bits, least significant first, slow clock
   task automatic send_bits(input logic [27:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         sdata = v[i];
         cyc(4);
         sck = 1'b1;
         cyc(4);
         sck = 1'b0;
      end
   endtask

   task automatic open_wr(input logic [11:0] a);
      sload_n = 1'b0;
      cyc(4);
      send_bits({16'h0000, a}, 12);
   endtask

   task automatic close_wr();
      cyc(4);
      sload_n = 1'b1;
      sdata = ~sdata;
      cyc(8);
   endtask

   task automatic wr(input logic [11:0] a, input logic [27:0] d, input int n);
      open_wr(a);
      send_bits(d, n);
      close_wr();
   endtask

   task automatic frame();
      vsync = 1'b0;
      cyc(8);
      vsync = 1'b1;
      cyc(4);
   endtask

   // Main sequence
   initial begin
      logic [31:0] t;
      logic [14:0] fe;
      logic [9:0] amp;
      logic [9:0] clamp;
      logic [11:0] a;
      int p0;
      cyc(2);
      chk(stby, 16'h0003);
      chk(clamp_on, 16'h0001);
      chk(settle, 16'h0000);
      chk(sg_o, 16'h0001);
      chk(amp_o, 16'h000f);
      chk(mdb_o, mdb(10'h00f));
      chk(clamp_o, 16'h01ec);
      i_reset_n = 1'b1;
      cyc(4);
      chk(oe, 16'h0001);
      // Every substrate source code with random control bits
      for (int k = 0; k < 16; k++) begin
         t = rnd();
         fe = t[14:0] & `AFE_FE_MASK;
         fe[14:11] = k[3:0];
         srcs = t[31:16];
         wr(`AFE_OFF_FRONTEND, {13'h0000, fe}, 28);
         blank = 1'b1;
         cyc(2);
         chk(stby, {14'h0000, fe[1:0]});
         chk(clamp_on, {15'h0000, fe[2]});
         chk(settle, {15'h0000, fe[3]});
         chk(sub_out, {15'h0000, srcs[k]});
         chk(restore_en, {15'h0000, ~fe[6]});
         blank = 1'b0;
         cyc(2);
         chk(restore_en, 16'h0001);
      end
      // Short word and unmapped place leave control alone
      wr(`AFE_OFF_FRONTEND, 28'h0000000, 20);
      wr(12'h002, 28'h0000000, 28);
      chk({stby, clamp_on, settle}, {12'h000, fe[1:0], fe[2], fe[3]});
      // Output path: transparent, blanking levels, latch, tri-state
      wr(`AFE_OFF_FRONTEND, 28'h0000024, 28);
      wr(`AFE_OFF_DOUT_CTRL, 28'h000000a, 28);
      t = rnd();
      adc = t[11:0];
      cyc(2);
      chk(dout, {4'h0, t[11:0]});
      blank = 1'b1;
      cyc(2);
      chk(dout, 16'h007b);
      wr(`AFE_OFF_FRONTEND, 28'h0000004, 28);
      chk(dout, 16'h0000);
      blank = 1'b0;
      wr(`AFE_OFF_DOUT_CTRL, 28'h0000008, 28);
      adc = t[23:12];
      phase = 1'b1;
      cyc(1);
      phase = 1'b0;
      adc = ~t[23:12];
      cyc(3);
      chk(dout, {4'h0, t[23:12]});
      wr(`AFE_OFF_DOUT_CTRL, 28'h0000009, 28);
      chk(oe, 16'h0000);
      wr(`AFE_OFF_DOUT_CTRL, 28'h0000008, 28);
      chk(oe, 16'h0001);
      // Frame registers by auto-increment, quick re-clamp armed
      wr(`AFE_OFF_FRONTEND, 28'h0000014, 28);
      t = rnd();
      amp = t[9:0] | 10'h200;
      clamp = t[19:10];
      open_wr(`AFE_OFF_SAMPLER_GAIN);
      send_bits({26'h0000000, t[21:20]}, 28);
      send_bits({18'h00000, amp}, 28);
      send_bits({18'h00000, clamp}, 28);
      close_wr();
      chk(amp_o, 16'h000f);
      chk(sg_o, 16'h0001);
      p0 = pulses;
      frame();
      chk(sg_o, {14'h0000, t[21:20]});
      chk(amp_o, {6'h00, amp});
      chk(mdb_o, mdb(amp));
      chk(clamp_o, {6'h00, clamp});
      chk(pulses - p0, 16'h0001);
      // Blanking level follows the applied clamp target
      wr(`AFE_OFF_FRONTEND, 28'h0000024, 28);
      blank = 1'b1;
      phase = 1'b1;
      cyc(1);
      phase = 1'b0;
      cyc(1);
      chk(dout, {8'h00, clamp[9:2]});
      blank = 1'b0;
      // Re-clamp disarmed: gain change gives no pulse
      wr(`AFE_OFF_FRONTEND, 28'h0000004, 28);
      wr(`AFE_OFF_AMP_GAIN, {18'h00000, amp ^ 10'h001}, 28);
      p0 = pulses;
      frame();
      chk(amp_o, {6'h00, amp ^ 10'h001});
      chk(pulses - p0, 16'h0000);
      // Every sampler gain code
      for (int c = 0; c < 4; c++) begin
         wr(`AFE_OFF_SAMPLER_GAIN, {26'h0000000, c[1:0]}, 28);
         frame();
         chk(sg_o, {14'h0000, c[1:0]});
         chk(db, sg_db(c[1:0]));
      end
      give_verdict();
   end
endmodule
